// file: hdl/dsa_byte_ram.sv
// Data memory built as two byte-wide halves with one read and one write port
`include "dsa_cfg.svh"

module dsa_byte_ram (
    // Clock
    input wire logic i_clk,
    // Read port
    input wire logic [`DSA_RAM_WORD_AW-1:0] i_rd_addr,
    output logic [15:0] o_rd_data,
    // Write port
    input wire logic [`DSA_RAM_WORD_AW-1:0] i_wr_addr,
    input wire logic i_we_lo,
    input wire logic i_we_hi,
    input wire logic [15:0] i_wr_data
);

    logic [7:0] mem_lo [0:(1<<`DSA_RAM_WORD_AW)-1];
    logic [7:0] mem_hi [0:(1<<`DSA_RAM_WORD_AW)-1];
    logic [15:0] rd_data_reg;

    // ------------------------------------------------------------
    // Shared word decode, separate byte strobes
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_we_lo) begin
            mem_lo[i_wr_addr] <= i_wr_data[7:0];
        end
        if (i_we_hi) begin
            mem_hi[i_wr_addr] <= i_wr_data[15:8];
        end
        rd_data_reg <= {mem_hi[i_rd_addr], mem_lo[i_rd_addr]};
    end

    assign o_rd_data = rd_data_reg;

endmodule // dsa_byte_ram

// file: hdl/dsa_cfg.svh
// Offsets, field positions, step sizes and working register constants of the data space access unit
`ifndef DSA_CFG_SVH
`define DSA_CFG_SVH

// ------------------------------------------------------------
// Address space layout
// ------------------------------------------------------------
`define DSA_ADDR_W 16
`define DSA_WIN_BIT 15
`define DSA_RAM_LIMIT 16'h4000
`define DSA_RAM_WORD_AW 13
`define DSA_NEAR_MASK 16'h1fff

// ------------------------------------------------------------
// Post-increment steps and working registers
// ------------------------------------------------------------
`define DSA_INC_BYTE 16'h0001
`define DSA_INC_WORD 16'h0002
`define DSA_NUM_WREG 16
`define DSA_WREG_RESET 16'h0000

`endif

// file: hdl/dsa_data_space.sv
// Data space access unit: two address generators, byte lanes, window and traps
// Notes on behaviour
// - Effective addresses are 16 bits, each naming one byte of 64 Kbytes.
// - Top address bit low selects memory; high selects the program window.
// - 16 Kbytes of memory implemented; other reads return zero.
// - Low byte lives at the even address, high byte at odd.
// - Post-increment adds 1 for byte and 2 for word accesses.
// - Byte reads fetch the word; address bit 0 picks byte onto low lane.
// - Memory has two byte halves with shared decode and separate strobes.
// - Odd-address word writes are not performed; odd-address word reads and writes raise an address trap.
// - Misaligned read completes, misaligned write suppressed; trap follows.
// - Byte load into a working register keeps its high byte.
// - Sign-extend widens signed byte; zero-extend clears the high byte.
// - Near region 0000h-1FFFh reached by 13-bit direct address field.
// - Full 16-bit direct address field reaches all of the data space.
// - Separate read and write address generation units.
// - Program window only active while its enable bit is set.
`include "dsa_cfg.svh"

module dsa_data_space (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Core control
    input wire logic i_program_space_window_enable,
    // Read address generation unit
    input wire logic i_rd_valid,
    input wire logic i_rd_byte,
    input wire dsa_pkg::dsa_amode_t i_rd_amode,
    input wire logic [15:0] i_rd_field,
    input wire logic [3:0] i_rd_ptr_idx,
    input wire logic i_rd_load,
    input wire logic [3:0] i_rd_dst_idx,
    // Write address generation unit
    input wire logic i_wr_valid,
    input wire logic i_wr_byte,
    input wire dsa_pkg::dsa_amode_t i_wr_amode,
    input wire logic [15:0] i_wr_field,
    input wire logic [3:0] i_wr_ptr_idx,
    input wire logic [15:0] i_wr_data,
    // Extend operations
    input wire logic i_ext_valid,
    input wire logic i_ext_sign,
    input wire logic [3:0] i_ext_idx,
    // Working register access
    input wire logic i_wreg_we,
    input wire logic [3:0] i_wreg_idx,
    input wire logic [15:0] i_wreg_wdata,
    input wire logic [3:0] i_wreg_sel,
    output logic [15:0] o_wreg_rdata,
    // Program window
    output logic o_win_req,
    output logic [14:0] o_win_addr,
    input wire logic [15:0] i_win_data,
    // Read result and trap
    output logic o_rd_valid,
    output logic [15:0] o_rd_data,
    output logic o_addr_trap
);

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------

    // Effective address from mode, literal field and pointer
    // Near mode masks the literal so it can never leave the near region
    function automatic logic [15:0] dsa_eff_addr(input dsa_pkg::dsa_amode_t m,
                                                 input logic [15:0] f,
                                                 input logic [15:0] p);
        logic [15:0] a;
        case (m)
            dsa_pkg::DSA_AM_NEAR: a = f & `DSA_NEAR_MASK;
            dsa_pkg::DSA_AM_FULL: a = f;
            default: a = p;
        endcase
        return a;
    endfunction

    // Step size follows the access size
    // Pointer arithmetic wraps at the top of the 64-Kbyte space
    function automatic logic [15:0] dsa_step(input logic is_byte);
        return is_byte ? `DSA_INC_BYTE : `DSA_INC_WORD;
    endfunction

    // Region decode of an effective address
    // Window bit tested first, so the window never aliases memory
    function automatic dsa_pkg::dsa_src_t dsa_region(input logic [15:0] a,
                                                     input logic win_en);
        dsa_pkg::dsa_src_t s;
        if (a[`DSA_WIN_BIT]) begin
            s = win_en ? dsa_pkg::DSA_SRC_WIN : dsa_pkg::DSA_SRC_ZERO;
        end else if (a < `DSA_RAM_LIMIT) begin
            s = dsa_pkg::DSA_SRC_RAM;
        end else begin
            s = dsa_pkg::DSA_SRC_ZERO;
        end
        return s;
    endfunction

    // ------------------------------------------------------------
    // Working registers and address generation
    // ------------------------------------------------------------
    logic [15:0] wreg_reg [0:`DSA_NUM_WREG-1];
    logic [15:0] wreg_next [0:`DSA_NUM_WREG-1];
    // Effective addresses of both generators
    logic [`DSA_ADDR_W-1:0] rd_eff_addr;
    logic [`DSA_ADDR_W-1:0] wr_eff_addr;
    dsa_pkg::dsa_src_t rd_src;
    dsa_pkg::dsa_src_t wr_src;
    logic rd_misalign;
    logic wr_misalign;
    logic wr_lo;
    logic wr_hi;
    logic [15:0] ram_wdata;
    logic [15:0] ram_rdata;

    // Independent read and write address generators
    // Both see the pointers as they stood before this edge
    always_comb begin
        rd_eff_addr = dsa_eff_addr(i_rd_amode, i_rd_field, wreg_reg[i_rd_ptr_idx]);
        wr_eff_addr = dsa_eff_addr(i_wr_amode, i_wr_field, wreg_reg[i_wr_ptr_idx]);
        rd_src = dsa_region(rd_eff_addr, i_program_space_window_enable);
        wr_src = dsa_region(wr_eff_addr, i_program_space_window_enable);
        rd_misalign = i_rd_valid && !i_rd_byte && rd_eff_addr[0];
        wr_misalign = i_wr_valid && !i_wr_byte && wr_eff_addr[0];
    end

    // Write strobes: only the matching byte half for byte writes, both halves for word writes, nothing outside memory
    always_comb begin
        wr_lo = 1'b0;
        wr_hi = 1'b0;
        if (i_wr_valid && !wr_misalign && wr_src == dsa_pkg::DSA_SRC_RAM) begin
            wr_lo = !i_wr_byte || !wr_eff_addr[0];
            wr_hi = !i_wr_byte || wr_eff_addr[0];
        end
        // Byte data goes out on both lanes; the strobe picks one
        ram_wdata = i_wr_byte ? {i_wr_data[7:0], i_wr_data[7:0]} : i_wr_data;
    end

    // Memory sees word addresses only; bit 0 picks the lane
    dsa_byte_ram u_ram (
        .i_clk(i_clk),
        .i_rd_addr(rd_eff_addr[`DSA_RAM_WORD_AW:1]),
        .o_rd_data(ram_rdata),
        .i_wr_addr(wr_eff_addr[`DSA_RAM_WORD_AW:1]),
        .i_we_lo(wr_lo),
        .i_we_hi(wr_hi),
        .i_wr_data(ram_wdata)
    );

    // ------------------------------------------------------------
    // Read pipeline stage one
    // ------------------------------------------------------------
    logic s1_valid_reg, s1_valid_next;
    logic s1_byte_reg, s1_byte_next;
    logic s1_lsb_reg, s1_lsb_next;
    logic s1_load_reg, s1_load_next;
    logic [3:0] s1_dst_reg, s1_dst_next;
    dsa_pkg::dsa_src_t s1_src_reg, s1_src_next;
    logic s1_trap_reg, s1_trap_next;
    logic win_req_reg, win_req_next;
    logic [14:0] win_addr_reg, win_addr_next;

    // Capture the read request and any misalignment
    // Misalignment from either generator shares one trap pulse
    always_comb begin
        s1_valid_next = i_rd_valid;
        s1_byte_next = i_rd_byte;
        s1_lsb_next = rd_eff_addr[0];
        s1_load_next = i_rd_valid && i_rd_load;
        s1_dst_next = i_rd_dst_idx;
        s1_src_next = rd_src;
        s1_trap_next = rd_misalign || wr_misalign;
        win_req_next = i_rd_valid && rd_src == dsa_pkg::DSA_SRC_WIN;
        win_addr_next = win_req_next ? rd_eff_addr[14:0] : win_addr_reg;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            s1_valid_reg <= 1'b0;
            s1_byte_reg <= 1'b0;
            s1_lsb_reg <= 1'b0;
            s1_load_reg <= 1'b0;
            s1_dst_reg <= 4'h0;
            s1_src_reg <= dsa_pkg::DSA_SRC_ZERO;
            s1_trap_reg <= 1'b0;
            win_req_reg <= 1'b0;
            win_addr_reg <= 15'h0000;
        end else begin
            s1_valid_reg <= s1_valid_next;
            s1_byte_reg <= s1_byte_next;
            s1_lsb_reg <= s1_lsb_next;
            s1_load_reg <= s1_load_next;
            s1_dst_reg <= s1_dst_next;
            s1_src_reg <= s1_src_next;
            s1_trap_reg <= s1_trap_next;
            win_req_reg <= win_req_next;
            win_addr_reg <= win_addr_next;
        end
    end

    // ------------------------------------------------------------
    // Read pipeline stage two: lane select and outputs
    // ------------------------------------------------------------
    logic [15:0] word_s1;
    logic [15:0] rd_result;
    logic rd_valid_reg, rd_valid_next;
    logic [15:0] rd_data_reg, rd_data_next;
    logic trap_reg, trap_next;

    // Pick the source word, then the byte lane
    // Window data is valid only while the request stands, so taken here
    always_comb begin
        case (s1_src_reg)
            dsa_pkg::DSA_SRC_RAM: word_s1 = ram_rdata;
            dsa_pkg::DSA_SRC_WIN: word_s1 = i_win_data;
            default: word_s1 = 16'h0000;
        endcase
        if (s1_byte_reg) begin
            rd_result = {8'h00, s1_lsb_reg ? word_s1[15:8] : word_s1[7:0]};
        end else begin
            rd_result = word_s1;
        end
        rd_valid_next = s1_valid_reg;
        rd_data_next = s1_valid_reg ? rd_result : rd_data_reg;
        trap_next = s1_trap_reg;
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rd_valid_reg <= 1'b0;
            rd_data_reg <= 16'h0000;
            trap_reg <= 1'b0;
        end else begin
            rd_valid_reg <= rd_valid_next;
            rd_data_reg <= rd_data_next;
            trap_reg <= trap_next;
        end
    end

    // ------------------------------------------------------------
    // Working register updates
    // ------------------------------------------------------------
    logic [15:0] wreg_rdata_reg, wreg_rdata_next;

    // Later assignments win: load, extend, read data, then increments
    // A post-increment wins over a load into its own pointer
    // Extend works on the register as it stood before this edge
    always_comb begin
        for (int i = 0; i < `DSA_NUM_WREG; i++) begin
            wreg_next[i] = wreg_reg[i];
        end
        if (i_wreg_we) begin
            wreg_next[i_wreg_idx] = i_wreg_wdata;
        end
        if (i_ext_valid) begin
            if (i_ext_sign) begin
                wreg_next[i_ext_idx] = {{8{wreg_reg[i_ext_idx][7]}},
                                        wreg_reg[i_ext_idx][7:0]};
            end else begin
                wreg_next[i_ext_idx] = {8'h00, wreg_reg[i_ext_idx][7:0]};
            end
        end
        if (s1_load_reg) begin
            if (s1_byte_reg) begin
                wreg_next[s1_dst_reg] = {wreg_reg[s1_dst_reg][15:8], rd_result[7:0]};
            end else begin
                wreg_next[s1_dst_reg] = rd_result;
            end
        end
        if (i_wr_valid && i_wr_amode == dsa_pkg::DSA_AM_POSTINC) begin
            wreg_next[i_wr_ptr_idx] = wreg_reg[i_wr_ptr_idx] + dsa_step(i_wr_byte);
        end
        if (i_rd_valid && i_rd_amode == dsa_pkg::DSA_AM_POSTINC) begin
            wreg_next[i_rd_ptr_idx] = wreg_reg[i_rd_ptr_idx] + dsa_step(i_rd_byte);
        end
        wreg_rdata_next = wreg_reg[i_wreg_sel];
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            for (int i = 0; i < `DSA_NUM_WREG; i++) begin
                wreg_reg[i] <= `DSA_WREG_RESET;
            end
            wreg_rdata_reg <= `DSA_WREG_RESET;
        end else begin
            for (int i = 0; i < `DSA_NUM_WREG; i++) begin
                wreg_reg[i] <= wreg_next[i];
            end
            wreg_rdata_reg <= wreg_rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs straight from flip-flops
    // ------------------------------------------------------------
    // No input reaches an output in the same cycle
    assign o_rd_valid = rd_valid_reg;
    assign o_rd_data = rd_data_reg;
    assign o_addr_trap = trap_reg;
    assign o_win_req = win_req_reg;
    assign o_win_addr = win_addr_reg;
    assign o_wreg_rdata = wreg_rdata_reg;

endmodule // dsa_data_space

// file: hdl/dsa_pkg.sv
// Types shared by the data space access unit
package dsa_pkg;

    // Addressing modes of an address generation unit
    typedef enum logic [1:0] {
        DSA_AM_NEAR,
        DSA_AM_FULL,
        DSA_AM_IND,
        DSA_AM_POSTINC
    } dsa_amode_t;

    // Source of read data
    typedef enum logic [1:0] {
        DSA_SRC_ZERO,
        DSA_SRC_RAM,
        DSA_SRC_WIN
    } dsa_src_t;

endpackage

// file: verif/dsa_data_space_props.sv
// Port assertions of the data space access unit
module dsa_data_space_props (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Requests
    input wire logic i_program_space_window_enable,
    input wire logic i_rd_valid,
    input wire logic i_rd_byte,
    input wire dsa_pkg::dsa_amode_t i_rd_amode,
    input wire logic [15:0] i_rd_field,
    input wire logic i_wr_valid,
    input wire logic i_wr_byte,
    input wire dsa_pkg::dsa_amode_t i_wr_amode,
    input wire logic [15:0] i_wr_field,
    input wire logic [15:0] i_win_data,
    // Results
    input wire logic o_win_req,
    input wire logic [14:0] o_win_addr,
    input wire logic o_rd_valid,
    input wire logic [15:0] o_rd_data,
    input wire logic o_addr_trap
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------
    // Helpers
    // ----------
    logic rd_full;
    logic wr_full;
    logic win_full;
    // Direct full-address requests
    assign rd_full = i_rd_valid && (i_rd_amode == dsa_pkg::DSA_AM_FULL);
    assign wr_full = i_wr_valid && (i_wr_amode == dsa_pkg::DSA_AM_FULL);
    assign win_full = rd_full && i_rd_field[15] && i_program_space_window_enable;
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_reset);
    // Window fetch then answer
    sequence s_win_fetch;
        ##1 o_win_req ##1 o_rd_valid;
    endsequence
    // ----------
    // Assertions
    // ----------
    a_rd_answer: assert property (i_rd_valid |-> ##2 o_rd_valid)
        else $error("read answer missing");
    a_rd_cause: assert property (o_rd_valid |-> $past(i_rd_valid, 2))
        else $error("read answer without request");
    a_win_addr: assert property (win_full
        |=> o_win_req && {1'b1, o_win_addr} == $past(i_rd_field))
        else $error("window address wrong");
    a_win_off: assert property (i_rd_valid && !i_program_space_window_enable |=> !o_win_req)
        else $error("window used while disabled");
    a_win_data: assert property (win_full && !i_rd_byte && !i_rd_field[0]
        |-> s_win_fetch ##0 (o_rd_data == $past(i_win_data)))
        else $error("window data not returned");
    a_zero_gap: assert property (rd_full && i_rd_field[15:14] == 2'b01
        |-> ##2 o_rd_data == 16'h0000)
        else $error("unimplemented read not zero");
    a_odd_trap: assert property (rd_full && !i_rd_byte && i_rd_field[0] |-> ##2 o_addr_trap)
        else $error("misaligned word read without trap");
    a_trap_cause: assert property (o_addr_trap
        |-> ($past(i_rd_valid, 2) && !$past(i_rd_byte, 2))
        || ($past(i_wr_valid, 2) && !$past(i_wr_byte, 2)))
        else $error("trap without word access");
    a_byte_lane: assert property (i_rd_valid && i_rd_byte |-> ##2 o_rd_data[15:8] == 8'h00)
        else $error("byte read high lane not clear");
    a_oob_quiet: assert property (wr_full && i_wr_field[15:14] != 2'b00 && !i_wr_field[0]
        && !i_rd_valid |-> ##2 !o_addr_trap)
        else $error("dropped write raised trap");
endmodule // dsa_data_space_props

bind dsa_data_space dsa_data_space_props dsa_data_space_props_inst (
    .i_clk, .i_reset, .i_program_space_window_enable, .i_rd_valid, .i_rd_byte,
    .i_rd_amode, .i_rd_field, .i_wr_valid, .i_wr_byte, .i_wr_amode, .i_wr_field,
    .i_win_data, .o_win_req, .o_win_addr, .o_rd_valid, .o_rd_data, .o_addr_trap
);

// file: verif/dsa_win_model.sv
// Behavioural program space seen through the data space window
module dsa_win_model (
    // Clock
    input wire logic i_clk,
    // Window request from the block
    input wire logic i_win_req,
    input wire logic [14:0] i_win_addr,
    output logic [15:0] o_win_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] pat;
    logic [15:0] last_reg = 16'h0000;
    // Stored word is a fixed pattern of its address
    assign pat = {1'b1, i_win_addr} ^ 16'h3c5a;
    // Valid only during the request, inverted stale word otherwise
    assign o_win_data = i_win_req ? pat : ~last_reg;
    // Remember the last word handed out
    always @(posedge i_clk) begin
        if (i_win_req) begin
            last_reg <= pat;
        end
    end
endmodule // dsa_win_model

// file: verif/testbench.sv
// Self-checking testbench of the data space access unit
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam dsa_pkg::dsa_amode_t am_near = dsa_pkg::DSA_AM_NEAR;
    localparam dsa_pkg::dsa_amode_t am_full = dsa_pkg::DSA_AM_FULL;
    localparam dsa_pkg::dsa_amode_t am_ind = dsa_pkg::DSA_AM_IND;
    localparam dsa_pkg::dsa_amode_t am_pinc = dsa_pkg::DSA_AM_POSTINC;
    // ----------
    // Signals
    // ----------
    logic i_clk, i_reset, i_program_space_window_enable;
    logic i_rd_valid, i_rd_byte, i_rd_load, i_wr_valid, i_wr_byte;
    logic i_ext_valid, i_ext_sign, i_wreg_we, o_win_req, o_rd_valid, o_addr_trap;
    dsa_pkg::dsa_amode_t i_rd_amode, i_wr_amode;
    logic [15:0] i_rd_field, i_wr_field, i_wr_data, i_wreg_wdata, i_win_data;
    logic [15:0] o_wreg_rdata, o_rd_data;
    logic [3:0] i_rd_ptr_idx, i_rd_dst_idx, i_wr_ptr_idx, i_ext_idx, i_wreg_idx, i_wreg_sel;
    logic [14:0] o_win_addr;
    int errors = 0;
    int cmp_count = 0;
    // Block and program space model
    dsa_data_space dsa_data_space_inst (.i_clk, .i_reset, .i_program_space_window_enable,
        .i_rd_valid, .i_rd_byte, .i_rd_amode, .i_rd_field, .i_rd_ptr_idx, .i_rd_load,
        .i_rd_dst_idx, .i_wr_valid, .i_wr_byte, .i_wr_amode, .i_wr_field, .i_wr_ptr_idx,
        .i_wr_data, .i_ext_valid, .i_ext_sign, .i_ext_idx, .i_wreg_we, .i_wreg_idx,
        .i_wreg_wdata, .i_wreg_sel, .o_wreg_rdata, .o_win_req, .o_win_addr, .i_win_data,
        .o_rd_valid, .o_rd_data, .o_addr_trap);
    dsa_win_model dsa_win_model_inst (.i_clk, .i_win_req(o_win_req),
        .i_win_addr(o_win_addr), .o_win_data(i_win_data));
    // Clock at 25 MHz
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    // ----------
    // Shared tasks
    // ----------
    task automatic tally_and_finish();
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic rd(input logic b, input dsa_pkg::dsa_amode_t m, input logic [15:0] f,
            input logic [15:0] e, input logic t = 1'b0, input logic [3:0] p = 4'h0,
            input logic ld = 1'b0, input logic [3:0] d = 4'h0);
        @(posedge i_clk);
        {i_rd_valid, i_rd_byte, i_rd_load} <= {1'b1, b, ld};
        i_rd_amode <= m;
        {i_rd_field, i_rd_ptr_idx, i_rd_dst_idx} <= {f, p, d};
        @(posedge i_clk);
        {i_rd_valid, i_rd_load} <= 2'h0;
        @(posedge i_clk);
        #1;
        chk({15'h0000, o_rd_valid}, 16'h0001);
        chk(o_rd_data, e);
        chk({15'h0000, o_addr_trap}, {15'h0000, t});
    endtask
    task automatic wr(input logic b, input dsa_pkg::dsa_amode_t m, input logic [15:0] f,
            input logic [15:0] v, input logic t = 1'b0, input logic [3:0] p = 4'h0);
        @(posedge i_clk);
        {i_wr_valid, i_wr_byte, i_wr_field, i_wr_data} <= {1'b1, b, f, v};
        i_wr_amode <= m;
        i_wr_ptr_idx <= p;
        @(posedge i_clk);
        i_wr_valid <= 1'b0;
        @(posedge i_clk);
        #1;
        chk({15'h0000, o_addr_trap}, {15'h0000, t});
    endtask
    task automatic setw(input logic [3:0] i, input logic [15:0] v);
        @(posedge i_clk);
        {i_wreg_we, i_wreg_idx, i_wreg_wdata} <= {1'b1, i, v};
        @(posedge i_clk);
        i_wreg_we <= 1'b0;
    endtask
    task automatic getw(input logic [3:0] i, input logic [15:0] e);
        @(posedge i_clk);
        i_wreg_sel <= i;
        @(posedge i_clk);
        #1;
        chk(o_wreg_rdata, e);
    endtask
    task automatic ext(input logic [3:0] i, input logic s);
        @(posedge i_clk);
        {i_ext_valid, i_ext_sign, i_ext_idx} <= {1'b1, s, i};
        @(posedge i_clk);
        i_ext_valid <= 1'b0;
    endtask
    // ----------
    // Scenarios
    // ----------
    task automatic t_lanes();
        @(posedge i_clk);
        #1;
        chk({o_rd_data[14:0], o_rd_valid}, 16'h0000);
        getw(4'h0, 16'h0000);
        wr(1'b0, am_full, 16'h0100, 16'h1234);
        wr(1'b1, am_full, 16'h0101, 16'h00ab);
        rd(1'b0, am_full, 16'h0100, 16'hab34);
        rd(1'b1, am_full, 16'h0100, 16'h0034);
        rd(1'b1, am_full, 16'h0101, 16'h00ab);
        wr(1'b0, am_full, 16'h3ffe, 16'hc3a5);
        rd(1'b0, am_full, 16'h3ffe, 16'hc3a5);
        rd(1'b0, am_near, 16'he100, 16'hab34);
    endtask
    task automatic t_zero_window();
        wr(1'b0, am_full, 16'h4100, 16'h7777, 1'b0);
        rd(1'b0, am_full, 16'h4100, 16'h0000);
        rd(1'b1, am_full, 16'h7fff, 16'h0000);
        rd(1'b0, am_full, 16'h8a42, 16'h0000);
        @(posedge i_clk);
        i_program_space_window_enable <= 1'b1;
        rd(1'b0, am_full, 16'h8a42, 16'hb618);
        rd(1'b1, am_full, 16'h8a43, 16'h00b6);
        @(posedge i_clk);
        i_program_space_window_enable <= 1'b0;
    endtask
    task automatic t_misalign();
        wr(1'b0, am_near, 16'he200, 16'h5555);
        wr(1'b0, am_full, 16'h0201, 16'hffff, 1'b1);
        rd(1'b0, am_full, 16'h0201, 16'h5555, 1'b1, 4'h0, 1'b1, 4'h8);
        getw(4'h8, 16'h5555);
    endtask
    task automatic t_pointers();
        setw(4'h3, 16'h0100);
        setw(4'h4, 16'hbeef);
        rd(1'b1, am_pinc, 16'h0000, 16'h0034, 1'b0, 4'h3, 1'b1, 4'h4);
        getw(4'h4, 16'hbe34);
        getw(4'h3, 16'h0101);
        setw(4'h3, 16'h0100);
        rd(1'b0, am_pinc, 16'h0000, 16'hab34, 1'b0, 4'h3);
        getw(4'h3, 16'h0102);
        setw(4'h5, 16'h0300);
        wr(1'b0, am_pinc, 16'h0000, 16'h2468, 1'b0, 4'h5);
        getw(4'h5, 16'h0302);
        setw(4'h6, 16'h0300);
        wr(1'b1, am_ind, 16'h0000, 16'h0011, 1'b0, 4'h6);
        rd(1'b0, am_ind, 16'h0000, 16'h2411, 1'b0, 4'h6);
    endtask
    task automatic t_extend();
        setw(4'h7, 16'h1280);
        ext(4'h7, 1'b1);
        getw(4'h7, 16'hff80);
        setw(4'h7, 16'hab7f);
        ext(4'h7, 1'b1);
        getw(4'h7, 16'h007f);
        setw(4'h7, 16'hff7f);
        ext(4'h7, 1'b0);
        getw(4'h7, 16'h007f);
    endtask
    // Watchdog against a hang
    initial begin
        #100000;
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        tally_and_finish();
    end
    // Main sequence
    initial begin
        {i_rd_valid, i_rd_byte, i_rd_load, i_wr_valid, i_wr_byte} = 5'h00;
        {i_ext_valid, i_ext_sign, i_wreg_we, i_program_space_window_enable} = 4'h0;
        {i_rd_field, i_wr_field, i_wr_data, i_wreg_wdata} = '0;
        {i_rd_ptr_idx, i_rd_dst_idx, i_wr_ptr_idx, i_ext_idx, i_wreg_idx, i_wreg_sel} = '0;
        i_rd_amode = am_full;
        i_wr_amode = am_full;
        i_reset = 1'b1;
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        t_lanes();
        t_zero_window();
        t_misalign();
        t_pointers();
        t_extend();
        tally_and_finish();
    end
endmodule // testbench
